// file: cic_interp_chain.sv
// One transmit channel'comb_scale_shift interpolation chain with its APB registers.
// Assumes upstream I/Q samples on pclk with valid/ready and a downstream
// stage that takes every out_valid strobe without back-pressure.
`timescale 1ns/100ps
`default_nettype none
`include "cic_chain_regs.svh"

module cic_interp_chain #(
   parameter int IN_W       = 18,
   parameter int OUT_W      = 18,
   parameter int FIFO_DEPTH = 16
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [11:0]      paddr,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [31:0]      pwdata,
   input  wire logic [3:0]       pstrb,
   output logic [31:0]           prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic             in_valid,
   input  wire logic [IN_W-1:0]  in_i,
   input  wire logic [IN_W-1:0]  in_q,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic [OUT_W-1:0]      out_i,
   output logic [OUT_W-1:0]      out_q
);
   // Headroom for L5^4 * Lr up to 2^32 over the input word.
   localparam int ACC_W = IN_W + 32;
   localparam int CW    = $clog2(FIFO_DEPTH+1);

   // Register file. Writes to the read-only status and counter words are
   // ignored without an error, so a stray write cannot upset the stream.
   cic_chain_pkg::decim_field_t  decim_reg;
   cic_chain_pkg::interp_field_t interp_reg;
   cic_chain_pkg::l5_field_t     fifth_order_interp_setting_reg;
   cic_chain_pkg::scale_field_t  scale_reg;
   cic_chain_pkg::scale_field_t  scale_next;
   logic [1:0]                   ctrl_reg;
   logic [31:0]                  outcnt_reg;
   logic                         flush_pulse_reg;

   cic_chain_pkg::reg_index_t    idx;
   logic                         setup;
   logic                         wr_access;
   logic                         addr_ok;
   logic [31:0]                  rd_mux;
   logic [31:0]                  wr_word;
   logic [31:0]                  cur_word;
   logic [CW-1:0]                fifo_count;

   assign idx       = paddr[9:2];
   assign setup     = psel & ~penable;
   assign wr_access = psel & penable & pwrite & pready & ~pslverr;

   always_comb begin
      addr_ok = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
      rd_mux  = 32'h0000_0000;
      unique case (idx)
         `CIC_IDX_DECIM:  rd_mux = 32'(decim_reg);
         `CIC_IDX_INTERP: rd_mux = 32'(interp_reg);
         `CIC_IDX_L5:     rd_mux = 32'(fifth_order_interp_setting_reg);
         `CIC_IDX_SCALE:  rd_mux = 32'(scale_reg);
         `CIC_IDX_CTRL:   rd_mux = 32'(ctrl_reg);
         `CIC_IDX_STATUS: rd_mux = {15'h0000, out_valid, 8'h00, 8'(fifo_count)};
         `CIC_IDX_OUTCNT: rd_mux = outcnt_reg;
         default:         addr_ok = 1'b0;
      endcase
   end

   // Byte lanes merge into the current register content.
   always_comb begin
      unique case (idx)
         `CIC_IDX_DECIM:  cur_word = 32'(decim_reg);
         `CIC_IDX_INTERP: cur_word = 32'(interp_reg);
         `CIC_IDX_L5:     cur_word = 32'(fifth_order_interp_setting_reg);
         `CIC_IDX_SCALE:  cur_word = 32'(scale_reg);
         `CIC_IDX_CTRL:   cur_word = 32'(ctrl_reg);
         default:         cur_word = 32'h0000_0000;
      endcase
      for (int b = 0; b < 4; b++) begin
         wr_word[b*8 +: 8] = pstrb[b] ? pwdata[b*8 +: 8] : cur_word[b*8 +: 8];
      end
   end

   // Out-of-range shifts are pulled into the supported window.
   always_comb begin
      scale_next = wr_word[`CIC_SCALE_W-1:0];
      if (wr_word[31:`CIC_SCALE_W] != '0 || scale_next > `CIC_SCALE_MAX) begin
         scale_next = `CIC_SCALE_MAX;
      end else if (scale_next < `CIC_SCALE_MIN) begin
         scale_next = `CIC_SCALE_MIN;
      end
   end

   // Every access answers in its first access cycle; the answer is prepared
   // at the setup edge so that the bus outputs are plain flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~addr_ok;
         prdata  <= (setup && !pwrite && addr_ok) ? rd_mux : 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         decim_reg  <= `CIC_DECIM_RST;
         interp_reg <= `CIC_INTERP_RST;
         fifth_order_interp_setting_reg <= `CIC_L5_RST;
         scale_reg  <= `CIC_SCALE_RST;
         ctrl_reg   <= `CIC_CTRL_RST;
      end else if (wr_access) begin
         unique case (idx)
            `CIC_IDX_DECIM:  decim_reg  <= wr_word[`CIC_DECIM_W-1:0];
            `CIC_IDX_INTERP: interp_reg <= wr_word[`CIC_INTERP_W-1:0];
            `CIC_IDX_L5:
               fifth_order_interp_setting_reg <= wr_word[`CIC_L5_W-1:0];
            `CIC_IDX_SCALE:  scale_reg  <= scale_next;
            `CIC_IDX_CTRL:   ctrl_reg   <= {1'b0, wr_word[`CIC_CTRL_RUN_BIT]};
            default:         ctrl_reg   <= ctrl_reg;
         endcase
      end
   end

   // Flush is self-clearing: writing it clears the filter state once.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flush_pulse_reg <= 1'b0;
      end else begin
         flush_pulse_reg <= wr_access && (idx == `CIC_IDX_CTRL) &&
                            wr_word[`CIC_CTRL_FLUSH_BIT];
      end
   end

   // Input buffer. A flush in the cycle of a push drops that word, so
   // software flushes only while the input is held off or the FIFO is full.
   logic                  fifo_valid;
   logic [2*IN_W-1:0]     fifo_data;
   logic                  fifo_pop;

   sync_fifo #(
      .WIDTH (2*IN_W),
      .DEPTH (FIFO_DEPTH)
   ) u_in_fifo (
      .clk      (pclk),
      .rst_n    (presetn),
      .flush    (flush_pulse_reg),
      .wr_valid (in_valid),
      .wr_data  ({in_i, in_q}),
      .wr_ready (in_ready),
      .rd_valid (fifo_valid),
      .rd_data  (fifo_data),
      .rd_ready (fifo_pop),
      .count    (fifo_count)
   );

   // Rate strobes. A resampler tick is one step of its high-rate grid;
   // each tick is one master clock, so no faster clock is ever needed.
   // Ticks stall when the sample that a stage needs is not yet there.
   logic [`CIC_L5_W-1:0]     c5_phase_reg;
   logic [`CIC_INTERP_W-1:0] rs_phase_reg;
   logic [`CIC_DECIM_W-1:0]  dec_phase_reg;
   logic                     run;
   logic                     c5_avail;
   logic                     rs_tick;
   logic                     c5_tick;
   logic                     out_tick;

   assign run      = ctrl_reg[`CIC_CTRL_RUN_BIT];
   assign c5_avail = (c5_phase_reg != '0) | fifo_valid;
   assign rs_tick  = run & ((rs_phase_reg != '0) | c5_avail);
   assign c5_tick  = rs_tick & (rs_phase_reg == '0);
   assign fifo_pop = c5_tick & (c5_phase_reg == '0);
   assign out_tick = rs_tick & (dec_phase_reg == '0);

   // Phases wrap at the programmed factor; a factor lowered below the
   // current phase wraps at once instead of running the counter round.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         c5_phase_reg <= '0;
      end else if (flush_pulse_reg) begin
         c5_phase_reg <= '0;
      end else if (c5_tick) begin
         c5_phase_reg <= (c5_phase_reg >= fifth_order_interp_setting_reg) ? '0
                         : c5_phase_reg + `CIC_L5_W'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rs_phase_reg <= '0;
      end else if (flush_pulse_reg) begin
         rs_phase_reg <= '0;
      end else if (rs_tick) begin
         rs_phase_reg <= (rs_phase_reg >= interp_reg) ? '0
                         : rs_phase_reg + `CIC_INTERP_W'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dec_phase_reg <= '0;
      end else if (flush_pulse_reg) begin
         dec_phase_reg <= '0;
      end else if (rs_tick) begin
         dec_phase_reg <= (dec_phase_reg >= decim_reg) ? '0
                          : dec_phase_reg + `CIC_DECIM_W'(1);
      end
   end

   // Filter cores: I and Q each take the same two stages in series.
   // With L = M = 1 the two combs cancel the two integrators exactly,
   // so the resampler passes samples through unchanged.
   logic [ACC_W-1:0] c5_in_i;
   logic [ACC_W-1:0] c5_in_q;
   logic [ACC_W-1:0] c5_out_i;
   logic [ACC_W-1:0] c5_out_q;
   logic [ACC_W-1:0] rs_out_i;
   logic [ACC_W-1:0] rs_out_q;

   assign c5_in_i = ACC_W'($signed(fifo_data[2*IN_W-1:IN_W]));
   assign c5_in_q = ACC_W'($signed(fifo_data[IN_W-1:0]));

   cic_core #(
      .ORDER (5),
      .W     (ACC_W)
   ) u_c5_i (
      .clk     (pclk),
      .rst_n   (presetn),
      .clear   (flush_pulse_reg),
      .comb_en (fifo_pop),
      .din     (c5_in_i),
      .int_en  (c5_tick),
      .insert  (fifo_pop),
      .dout    (c5_out_i)
   );

   cic_core #(
      .ORDER (5),
      .W     (ACC_W)
   ) u_c5_q (
      .clk     (pclk),
      .rst_n   (presetn),
      .clear   (flush_pulse_reg),
      .comb_en (fifo_pop),
      .din     (c5_in_q),
      .int_en  (c5_tick),
      .insert  (fifo_pop),
      .dout    (c5_out_q)
   );

   cic_core #(
      .ORDER (2),
      .W     (ACC_W)
   ) u_rs_i (
      .clk     (pclk),
      .rst_n   (presetn),
      .clear   (flush_pulse_reg),
      .comb_en (c5_tick),
      .din     (c5_out_i),
      .int_en  (rs_tick),
      .insert  (c5_tick),
      .dout    (rs_out_i)
   );

   cic_core #(
      .ORDER (2),
      .W     (ACC_W)
   ) u_rs_q (
      .clk     (pclk),
      .rst_n   (presetn),
      .clear   (flush_pulse_reg),
      .comb_en (c5_tick),
      .din     (c5_out_q),
      .int_en  (rs_tick),
      .insert  (c5_tick),
      .dout    (rs_out_q)
   );

   // Shared scaler: an arithmetic shift frames the output bits, one step
   // per 6 dB. The low bits are kept without saturation, so a shift below
   // the safe minimum wraps instead of clipping.
   logic [ACC_W-1:0] sh_i;
   logic [ACC_W-1:0] sh_q;

   assign sh_i = ACC_W'($signed(rs_out_i) >>> scale_reg);
   assign sh_q = ACC_W'($signed(rs_out_q) >>> scale_reg);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid <= 1'b0;
         out_i     <= '0;
         out_q     <= '0;
      end else begin
         // Samples hold between strobes, so the next stage may take them late.
         out_valid <= out_tick;
         if (out_tick) begin
            out_i <= sh_i[OUT_W-1:0];
            out_q <= sh_q[OUT_W-1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         outcnt_reg <= 32'h0000_0000;
      end else if (out_tick) begin
         outcnt_reg <= outcnt_reg + 32'h0000_0001;
      end
   end
endmodule : cic_interp_chain

`default_nettype wire

// file: cic_chain_regs.svh
// Register indices, field widths, reset values and limits of the CIC chain.
// Assumes a 32-bit APB slave where byte address equals index times four.
`ifndef CIC_CHAIN_REGS_SVH
`define CIC_CHAIN_REGS_SVH

`define CIC_IDX_W             8
`define CIC_IDX_DECIM         8'h07
`define CIC_IDX_INTERP        8'h08
`define CIC_IDX_L5            8'h09
`define CIC_IDX_SCALE         8'h0a
`define CIC_IDX_CTRL          8'h0b
`define CIC_IDX_STATUS        8'h0c
`define CIC_IDX_OUTCNT        8'h0d

`define CIC_DECIM_W           9
`define CIC_INTERP_W          12
`define CIC_L5_W              8
`define CIC_SCALE_W           6

`define CIC_DECIM_RST         9'h000
`define CIC_INTERP_RST        12'h000
`define CIC_L5_RST            8'h00
`define CIC_SCALE_RST         6'h04
`define CIC_SCALE_MIN         6'h04
`define CIC_SCALE_MAX         6'h20
`define CIC_CTRL_RST          2'h1
`define CIC_CTRL_RUN_BIT      0
`define CIC_CTRL_FLUSH_BIT    1

`endif

// file: cic_chain_pkg.sv
// Types shared by the CIC interpolation chain files.
// Assumes cic_chain_regs.svh supplies the field widths.
`include "cic_chain_regs.svh"

package cic_chain_pkg;
   typedef logic [`CIC_DECIM_W-1:0]  decim_field_t;
   typedef logic [`CIC_INTERP_W-1:0] interp_field_t;
   typedef logic [`CIC_L5_W-1:0]     l5_field_t;
   typedef logic [`CIC_SCALE_W-1:0]  scale_field_t;
   typedef logic [`CIC_IDX_W-1:0]    reg_index_t;
endpackage : cic_chain_pkg

// file: sync_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a registered full flag.
// Assumes one clock; writer honours wr_ready, reader honours rd_valid.
`timescale 1ns/100ps
`default_nettype none

module sync_fifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 16
) (
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic                       flush,
   input  wire logic                       wr_valid,
   input  wire logic [WIDTH-1:0]           wr_data,
   output logic                            wr_ready,
   output logic                            rd_valid,
   output logic [WIDTH-1:0]                rd_data,
   input  wire logic                       rd_ready,
   output logic [$clog2(DEPTH+1)-1:0]      count
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [CW-1:0]    count_reg;
   logic [CW-1:0]    count_next;
   logic             push;
   logic             pop;

   assign push = wr_valid & wr_ready;
   assign pop  = rd_valid & rd_ready;
   assign rd_valid = (count_reg != '0);
   assign rd_data  = mem[rd_ptr_reg];
   assign count    = count_reg;

   always_comb begin
      count_next = count_reg;
      if (push && !pop) begin
         count_next = count_reg + CW'(1);
      end else if (pop && !push) begin
         count_next = count_reg - CW'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= wr_data;
      end
   end

   // Full is registered so the ready seen upstream is a clean flop output.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
         wr_ready   <= 1'b0;
      end else if (flush) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
         wr_ready   <= 1'b1;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + AW'(1);
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + AW'(1);
         end
         count_reg <= count_next;
         wr_ready  <= (count_next != CW'(DEPTH));
      end
   end
endmodule : sync_fifo

`default_nettype wire

// file: cic_core.sv
// Integrator-comb interpolator core of configurable order.
// Combs run on comb_en at the low rate; integrators run on int_en at the
// high rate and take the comb output only when insert is set (zero stuffing).
`timescale 1ns/100ps
`default_nettype none

module cic_core #(
   parameter int ORDER = 5,
   parameter int W     = 50
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         clear,
   input  wire logic         comb_en,
   input  wire logic [W-1:0] din,
   input  wire logic         int_en,
   input  wire logic         insert,
   output logic [W-1:0]      dout
);
   logic [W-1:0] comb_val [ORDER+1];
   logic [W-1:0] comb_dly [ORDER];
   logic [W-1:0] integ    [ORDER];

   assign comb_val[0] = din;
   assign dout        = integ[ORDER-1];

   // Wrap-around arithmetic is intended: only the final sum must fit W bits.
   for (genvar k = 0; k < ORDER; k++) begin : g_stage
      assign comb_val[k+1] = comb_val[k] - comb_dly[k];

      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            comb_dly[k] <= '0;
            integ[k]    <= '0;
         end else if (clear) begin
            comb_dly[k] <= '0;
            integ[k]    <= '0;
         end else begin
            if (comb_en) begin
               comb_dly[k] <= comb_val[k];
            end
            if (int_en) begin
               if (k == 0) begin
                  integ[k] <= integ[k] + (insert ? comb_val[ORDER] : '0);
               end else begin
                  integ[k] <= integ[k] + integ[k-1];
               end
            end
         end
      end
   end
endmodule : cic_core

`default_nettype wire

// file: cic_chain_sva.sv
// Checker of register bus timing, decode and output holding of one chain.
// Assumes it is bound to cic_interp_chain and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
`include "cic_chain_regs.svh"
module cic_chain_sva #(
   parameter int OUT_W = 18
) (
   input wire logic             pclk,
   input wire logic             presetn,
   input wire logic [11:0]      paddr,
   input wire logic             psel,
   input wire logic             penable,
   input wire logic             pwrite,
   input wire logic [31:0]      prdata,
   input wire logic             pready,
   input wire logic             pslverr,
   input wire logic             in_valid,
   input wire logic             in_ready,
   input wire logic             out_valid,
   input wire logic [OUT_W-1:0] out_i,
   input wire logic [OUT_W-1:0] out_q
);
   logic [7:0] idx;
   logic       bad;
   assign idx = paddr[9:2];
   assign bad = paddr[1:0] != 2'b00 || paddr[11:10] != 2'b00 ||
                idx < `CIC_IDX_DECIM || idx > `CIC_IDX_OUTCNT;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_READY_NEXT: assert property (psel && !penable |=> pready)
      else $error("late answer");
   AST_READY_ACCESS: assert property (pready |-> psel && penable)
      else $error("answer outside access");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("answer too long");
   AST_ERR_DECODE: assert property (pready |-> pslverr == bad)
      else $error("wrong decode error");
   AST_IDLE_ZERO: assert property (!pready |-> !pslverr && prdata == 0)
      else $error("bus not idle");
   AST_SCALE_RANGE: assert property (
      pready && !pwrite && !bad && idx == `CIC_IDX_SCALE
      |-> prdata >= 32'h4 && prdata <= 32'h20)
      else $error("scale out of range");
   AST_L5_WIDTH: assert property (
      pready && !pwrite && idx == `CIC_IDX_L5 |-> prdata[31:8] == 0)
      else $error("wide interp field");
   AST_RS_WIDTH: assert property (pready && !pwrite |->
      !(idx == `CIC_IDX_DECIM && prdata[31:9] != 0) &&
      !(idx == `CIC_IDX_INTERP && prdata[31:12] != 0))
      else $error("wide resampler field");
   AST_OUT_HOLD: assert property (
      !out_valid |-> $stable(out_i) && $stable(out_q))
      else $error("output moved without strobe");
   AST_FULL_BY_PUSH: assert property ($fell(in_ready) |-> $past(in_valid))
      else $error("ready fell without push");
endmodule : cic_chain_sva
bind cic_interp_chain cic_chain_sva #(.OUT_W(OUT_W)) u_sva (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .in_valid(in_valid),
   .in_ready(in_ready), .out_valid(out_valid), .out_i(out_i),
   .out_q(out_q));
`default_nettype wire

// file: sample_source.sv
// Upstream sample source in place of the coefficient filter stage.
// Assumes a word is taken at an edge where in_valid and in_ready are high.
`timescale 1ns/100ps
`default_nettype none
module sample_source (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        in_ready,
   input  wire logic        stall,
   input  wire logic        start,
   input  var  int          cnt,
   input  wire logic [17:0] xi,
   input  wire logic [17:0] xq,
   output logic             in_valid,
   output logic [17:0]      in_i,
   output logic [17:0]      in_q,
   output var  int          left
);
   int nxt;
   // An offered word is held until taken; between words the data lines
   // toggle, so a stale value can never pass for a fresh sample.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_valid <= 1'b0;
         in_i <= 18'h0;
         in_q <= 18'h0;
         left <= 0;
      end else begin
         nxt = start ? cnt : left - int'(in_valid && in_ready);
         left <= nxt;
         if (!(in_valid && !in_ready)) begin
            in_valid <= nxt > 0 && !stall;
            in_i <= (nxt > 0 && !stall) ? xi : ~in_i;
            in_q <= (nxt > 0 && !stall) ? xq : ~in_q;
         end
      end
   end
endmodule : sample_source
`default_nettype wire

// file: tb_cic_interp_chain.sv
// Self-checking bench of one chain channel fed by the sample source.
// Assumes the design, the source and the bound checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "cic_chain_regs.svh"
module tb_cic_interp_chain;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic        in_valid, in_ready, out_valid, start, stall, gaps = 1'b0;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, v;
   logic [3:0]  pstrb;
   logic [17:0] in_i, in_q, out_i, out_q, xi, xq;
   int          cnt, left, err_count, n_compared, n_out, x, y, base;
   int          sc[6] = '{0, 3, 4, 32, 33, 64};
   int          cf[5][4] = '{'{1, 1, 1, 4}, '{2, 1, 1, 4},
                '{4, 3, 2, 10}, '{3, 5, 3, 9}, '{32, 1, 1, 20}};
   cic_interp_chain DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .in_valid(in_valid), .in_i(in_i), .in_q(in_q), .in_ready(in_ready),
      .out_valid(out_valid), .out_i(out_i), .out_q(out_q));
   sample_source src (.pclk(pclk), .presetn(presetn), .in_ready(in_ready),
      .stall(stall), .start(start), .cnt(cnt), .xi(xi), .xq(xq),
      .in_valid(in_valid), .in_i(in_i), .in_q(in_q), .left(left));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk) if (presetn && out_valid === 1'b1) n_out++;
   always @(posedge pclk) stall <= gaps && $urandom_range(3) == 0;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int t;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 40);
      if (pready !== 1'b1) begin
         err_count++;
         $display("BAD %0t no bus answer", $time);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] i, input logic [31:0] d);
      apb(1'b1, {2'b00, i, 2'b00}, d);
   endtask : wr
   task automatic rdchk(input logic [7:0] i, input logic [31:0] d);
      apb(1'b0, {2'b00, i, 2'b00}, 32'h0);
      chk(q, d);
   endtask : rdchk
   task automatic send(input int n);
      @(posedge pclk);
      start <= 1'b1;
      cnt <= n;
      @(posedge pclk);
      start <= 1'b0;
   endtask : send
   // Waits until input and output have both been quiet for 100 cycles.
   task automatic settle();
      int k;
      k = 0;
      while (k < 100) begin
         @(posedge pclk);
         k = (out_valid === 1'b1 || in_valid === 1'b1) ? 0 : k + 1;
      end
   endtask : settle
   function automatic logic [31:0] clamp(input logic [31:0] s);
      return (s < 4) ? 32'h4 : (s > 32) ? 32'h20 : s;
   endfunction : clamp
   function automatic logic [31:0] dc(input int s, input int c);
      longint g;
      g = longint'(s) * (cf[c][0] ** 4) * cf[c][1];
      return {14'h0000, 18'(g >>> cf[c][3])};
   endfunction : dc
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : results
   initial begin
      repeat (60000) @(posedge pclk);
      err_count++;
      $display("BAD %0t watchdog expired", $time);
      results();
   end
   initial begin
      {presetn, psel, penable, pwrite, start} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hf;
      {xi, xq, cnt} = '0;
      void'($urandom(32'h1f8cf238));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(`CIC_IDX_DECIM, 32'h0);
      rdchk(`CIC_IDX_INTERP, 32'h0);
      rdchk(`CIC_IDX_L5, 32'h0);
      rdchk(`CIC_IDX_SCALE, 32'h4);
      rdchk(`CIC_IDX_CTRL, 32'h1);
      apb(1'b0, 12'h080, 32'h0);
      chk({31'h0, e}, 32'h1);
      apb(1'b1, 12'h025, 32'h77);
      chk({31'h0, e}, 32'h1);
      rdchk(`CIC_IDX_L5, 32'h0);
      $display("test reset and decode done");
      for (int k = 0; k < 10; k++) begin
         v = (k < 6) ? 32'(sc[k]) : $urandom_range(70);
         wr(`CIC_IDX_SCALE, v);
         rdchk(`CIC_IDX_SCALE, clamp(v));
         v = $urandom;
         wr(`CIC_IDX_DECIM, v);
         wr(`CIC_IDX_INTERP, v);
         wr(`CIC_IDX_L5, v);
         rdchk(`CIC_IDX_DECIM, v & 32'h1ff);
         rdchk(`CIC_IDX_INTERP, v & 32'hfff);
         rdchk(`CIC_IDX_L5, v & 32'hff);
      end
      pstrb <= 4'h2;
      wr(`CIC_IDX_DECIM, ~v);
      pstrb <= 4'hf;
      rdchk(`CIC_IDX_DECIM, (~v & 32'h100) | (v & 32'hff));
      $display("test fields done");
      for (int c = 0; c < 5; c++) begin
         x = (c == 4) ? -131072 : $urandom_range(131071) - 65536;
         y = $urandom_range(131071) - 65536;
         xi <= 18'(x);
         xq <= 18'(y);
         gaps <= c[0];
         wr(`CIC_IDX_L5, 32'(cf[c][0] - 1));
         wr(`CIC_IDX_INTERP, 32'(cf[c][1] - 1));
         wr(`CIC_IDX_DECIM, 32'(cf[c][2] - 1));
         wr(`CIC_IDX_SCALE, 32'(cf[c][3]));
         wr(`CIC_IDX_CTRL, 32'h3);
         base = n_out;
         send(40);
         settle();
         chk(32'(out_i), dc(x, c));
         chk(32'(out_q), dc(y, c));
         chk({31'h0, n_out - base >= 38 * cf[c][0] * cf[c][1] / cf[c][2] - 10
            && n_out - base <= 40 * cf[c][0] * cf[c][1] / cf[c][2] + 1},
            32'h1);
         $display("test config %0d done", c);
      end
      rdchk(`CIC_IDX_OUTCNT, 32'(n_out));
      gaps <= 1'b0;
      wr(`CIC_IDX_CTRL, 32'h0);
      send(20);
      for (int k = 0; k < 100 && in_ready !== 1'b0; k++) @(posedge pclk);
      rdchk(`CIC_IDX_STATUS, 32'h10);
      wr(`CIC_IDX_CTRL, 32'h2);
      rdchk(`CIC_IDX_CTRL, 32'h0);
      for (int k = 0; k < 100 && left != 0; k++) @(posedge pclk);
      rdchk(`CIC_IDX_STATUS, 32'h4);
      wr(`CIC_IDX_CTRL, 32'h1);
      settle();
      rdchk(`CIC_IDX_STATUS, 32'h0);
      $display("test fifo done");
      results();
   end
endmodule : tb_cic_interp_chain
`default_nettype wire
